//--- inc/frame_decoder_defines.svh
// constants for the bit-oriented frame type decoder
`ifndef FRAME_DECODER_DEFINES_SVH
`define FRAME_DECODER_DEFINES_SVH
`define FLAG_OCTET 8'h7E
`define OCT_ADDR 4'h1
`define OCT_CTRL 4'h2
`define OCT_PTYPE 4'h5
`define OCT_LENS 4'h6
`define OCT_CALLED 4'h7
`define OCT_CALLING 4'h8
`define OCT_FACLEN 4'h9
`define PT_CALL_REQ 8'h0B
`define PT_CALL_ACC 8'h0F
`define UMASK 8'hEF
`define U_NRM 8'h83
`define U_ARM 8'h03
`define U_ABM 8'h2F
`define U_NRME 8'hCF
`define U_ARME 8'h4F
`define U_ABME 8'h6F
`define OCT_LAST 4'hF
`define INFO_BIT 0
`define FMT_MSB 1
`define FMT_SUPER 2'h1
`define FMT_UNNUM 2'h3
`define PF_BIT 4
`define NR_MSB 7
`define NR_LSB 5
`define NS_MSB 3
`define NS_LSB 1
`define ST_MSB 3
`define ST_LSB 2
`define FAC_MSB 5
`endif

//--- inc/frame_decoder_pkg.sv
// types for the bit-oriented frame type decoder
package frame_decoder_pkg;
  typedef enum logic [1:0] {cls_none, cls_info, cls_super, cls_unnum} frame_class_t;
  typedef enum logic [2:0] {mode_none, mode_nrm, mode_arm, mode_abm,
    mode_nrme, mode_arme, mode_abme} mode_cmd_t;
  typedef enum logic [1:0] {pkt_none, pkt_call_req, pkt_call_acc} pkt_kind_t;
endpackage : frame_decoder_pkg

//--- core/octet_hold.sv
// small register holding one received octet
`timescale 1ns/1ps
`default_nettype none
module octet_hold #(
  parameter int W = 8
) (
  // clock, reset and enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // load port
  input wire logic load,
  input wire logic [W-1:0] din,
  // held value
  output logic [W-1:0] dout
);
  initial begin
    if (W < 1) $error("octet_hold width must be positive");
  end
  // loads on strobe, clears at reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dout <= '0;
    end else if (ce && load) begin
      dout <= din;
    end
  end
endmodule : octet_hold
`default_nettype wire

//--- core/frame_type_decoder.sv
// frame class, supervisory type, mode command and call packet decoder
// Functional notes
// [RULE1] rightmost control bit zero means information
// [RULE2] supervisory pattern marks supervisory frame
// [RULE3] supervisory bits 01, next two select type
// [RULE4] both rightmost bits one means unnumbered
// [RULE5] match mode commands ignoring poll bit
// [RULE6] match extended mode commands ignoring poll bit
// [RULE7] call request/accepted types and field octets
// [RULE8] frames bounded by 7E flag octets
// [RULE9] address tells command from response
// [RULE10] outputs valid one clock after control
`timescale 1ns/1ps
`default_nettype none
`include "frame_decoder_defines.svh"
module frame_type_decoder (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // observed octet stream
  input wire logic oct_valid,
  input wire logic [7:0] oct_data,
  // station address of the local side
  input wire logic [7:0] own_addr,
  // frame classification
  output logic ctrl_valid_q,
  output frame_decoder_pkg::frame_class_t class_q,
  output logic [1:0] super_type_q,
  output frame_decoder_pkg::mode_cmd_t mode_q,
  output logic poll_q,
  output logic [2:0] send_seq_q,
  output logic [2:0] recv_seq_q,
  output logic is_command_q,
  // call setup packet fields
  output logic pkt_valid_q,
  output frame_decoder_pkg::pkt_kind_t pkt_q,
  output logic [7:0] addr_lens_q,
  output logic [7:0] called_q,
  output logic [7:0] calling_q,
  output logic [5:0] fac_len_q
);
  // octet position within frame, 0 means idle/after flag
  logic [3:0] pos_q;
  logic in_frame_q;
  logic [7:0] addr_hold;
  // mode command match ignoring poll bit
  function automatic frame_decoder_pkg::mode_cmd_t mode_of(input logic [7:0] c);
    logic [7:0] m;
    m = c & `UMASK;
    case (m)
      `U_NRM: mode_of = frame_decoder_pkg::mode_nrm; // RULE5
      `U_ARM: mode_of = frame_decoder_pkg::mode_arm; // RULE5
      `U_ABM: mode_of = frame_decoder_pkg::mode_abm; // RULE5
      `U_NRME: mode_of = frame_decoder_pkg::mode_nrme; // RULE6
      `U_ARME: mode_of = frame_decoder_pkg::mode_arme; // RULE6
      `U_ABME: mode_of = frame_decoder_pkg::mode_abme; // RULE6
      default: mode_of = frame_decoder_pkg::mode_none;
    endcase
  endfunction : mode_of
  // decode wires
  wire logic take = ce && oct_valid;
  wire logic is_flag = oct_data == `FLAG_OCTET; // RULE8
  // frame octet number of the octet now offered, address is octet one
  wire logic [3:0] oct_num = pos_q + 4'h1;
  wire logic at_addr = take && !is_flag && in_frame_q && oct_num == `OCT_ADDR;
  wire logic at_ctrl = take && !is_flag && in_frame_q && oct_num == `OCT_CTRL;
  wire logic at_data = take && !is_flag && in_frame_q && oct_num > `OCT_CTRL;
  wire logic c_info = !oct_data[`INFO_BIT]; // RULE1
  wire logic c_super = oct_data[`FMT_MSB:0] == `FMT_SUPER; // RULE2 RULE3
  wire logic c_unnum = oct_data[`FMT_MSB:0] == `FMT_UNNUM; // RULE4
  wire logic pkt_ok = class_q == frame_decoder_pkg::cls_info;
  // captures address octet for command/response split
  octet_hold #(.W(8)) u_addr (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .load(at_addr),
    .din(oct_data),
    .dout(addr_hold)
  );
  // frame position tracking; flag opens or closes a frame
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pos_q <= 4'h0;
      in_frame_q <= 1'b0;
    end else if (take) begin
      if (is_flag) begin
        pos_q <= 4'h0; // RULE8
        in_frame_q <= 1'b1;
      end else if (in_frame_q && pos_q != `OCT_LAST) begin
        pos_q <= pos_q + 4'h1;
      end
    end
  end
  // control octet classification, held until next control octet; ctrl_valid_q clears at the next address octet
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_valid_q <= 1'b0;
      class_q <= frame_decoder_pkg::cls_none;
      super_type_q <= 2'h0;
      mode_q <= frame_decoder_pkg::mode_none;
      poll_q <= 1'b0;
      send_seq_q <= 3'h0;
      recv_seq_q <= 3'h0;
      is_command_q <= 1'b0;
    end else if (ce) begin
      if (at_addr) begin
        ctrl_valid_q <= 1'b0; // RULE10
      end else if (at_ctrl) begin
        ctrl_valid_q <= 1'b1; // RULE10
        poll_q <= oct_data[`PF_BIT];
        recv_seq_q <= oct_data[`NR_MSB:`NR_LSB];
        is_command_q <= addr_hold != own_addr; // RULE9
        send_seq_q <= c_info ? oct_data[`NS_MSB:`NS_LSB] : 3'h0; // RULE1 RULE2
        super_type_q <= c_super ? oct_data[`ST_MSB:`ST_LSB] : 2'h0; // RULE3
        mode_q <= c_unnum ? mode_of(oct_data) : frame_decoder_pkg::mode_none;
        if (c_info) begin
          class_q <= frame_decoder_pkg::cls_info; // RULE1
        end else if (c_super) begin
          class_q <= frame_decoder_pkg::cls_super; // RULE2
        end else begin
          class_q <= frame_decoder_pkg::cls_unnum; // RULE4
        end
      end
    end
  end
  // packet header fields in information frames
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pkt_valid_q <= 1'b0;
      pkt_q <= frame_decoder_pkg::pkt_none;
      addr_lens_q <= 8'h00;
      called_q <= 8'h00;
      calling_q <= 8'h00;
      fac_len_q <= 6'h00;
    end else if (ce) begin
      if (at_addr) begin
        pkt_valid_q <= 1'b0;
        pkt_q <= frame_decoder_pkg::pkt_none;
      end else if (at_data && pkt_ok) begin
        case (oct_num)
          `OCT_PTYPE: begin
            if (oct_data == `PT_CALL_REQ) begin
              pkt_q <= frame_decoder_pkg::pkt_call_req; // RULE7
            end else if (oct_data == `PT_CALL_ACC) begin
              pkt_q <= frame_decoder_pkg::pkt_call_acc; // RULE7
            end
          end
          `OCT_LENS: addr_lens_q <= oct_data; // RULE7
          `OCT_CALLED: called_q <= oct_data; // RULE7
          `OCT_CALLING: calling_q <= oct_data; // RULE7
          `OCT_FACLEN: begin
            fac_len_q <= oct_data[`FAC_MSB:0]; // RULE7
            pkt_valid_q <= pkt_q != frame_decoder_pkg::pkt_none;
          end
          default: begin
          end
        endcase
      end
    end
  end
  // checks
  chk_info_class: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
    at_ctrl && !oct_data[0] |=> class_q == frame_decoder_pkg::cls_info)
    else $error("info frame misclassified");
  chk_super_class: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
    at_ctrl && oct_data[1:0] == 2'b01 |=> class_q == frame_decoder_pkg::cls_super)
    else $error("supervisory frame misclassified");
  chk_super_type: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
    at_ctrl && c_super |=> super_type_q == $past(oct_data[3:2]))
    else $error("supervisory type wrong");
  chk_unnum_class: assert property (@(posedge core_clk) disable iff (!rstn) // RULE4
    at_ctrl && oct_data[1:0] == 2'b11 |=> class_q == frame_decoder_pkg::cls_unnum)
    else $error("unnumbered frame misclassified");
  // mode commands, one check per code, poll bit masked
  chk_mode_nrm: assert property (@(posedge core_clk) disable iff (!rstn) // RULE5
    at_ctrl && (oct_data & `UMASK) == `U_NRM |=> mode_q == frame_decoder_pkg::mode_nrm)
    else $error("normal mode command missed");
  chk_mode_arm: assert property (@(posedge core_clk) disable iff (!rstn) // RULE5
    at_ctrl && (oct_data & `UMASK) == `U_ARM |=> mode_q == frame_decoder_pkg::mode_arm)
    else $error("asynchronous response mode missed");
  chk_mode_abm: assert property (@(posedge core_clk) disable iff (!rstn) // RULE5
    at_ctrl && (oct_data & `UMASK) == `U_ABM |=> mode_q == frame_decoder_pkg::mode_abm)
    else $error("asynchronous balanced mode missed");
  chk_mode_nrme: assert property (@(posedge core_clk) disable iff (!rstn) // RULE6
    at_ctrl && (oct_data & `UMASK) == `U_NRME |=> mode_q == frame_decoder_pkg::mode_nrme)
    else $error("extended normal mode missed");
  chk_mode_arme: assert property (@(posedge core_clk) disable iff (!rstn) // RULE6
    at_ctrl && (oct_data & `UMASK) == `U_ARME |=> mode_q == frame_decoder_pkg::mode_arme)
    else $error("extended asynchronous mode missed");
  chk_mode_abme: assert property (@(posedge core_clk) disable iff (!rstn) // RULE6
    at_ctrl && (oct_data & `UMASK) == `U_ABME |=> mode_q == frame_decoder_pkg::mode_abme)
    else $error("extended balanced mode missed");
  // call setup packet type at its frame octet, fields only in info frames
  chk_call_req: assert property (@(posedge core_clk) disable iff (!rstn) // RULE7
    at_data && pkt_ok && oct_num == `OCT_PTYPE && oct_data == `PT_CALL_REQ
    |=> pkt_q == frame_decoder_pkg::pkt_call_req)
    else $error("call request missed");
  chk_call_acc: assert property (@(posedge core_clk) disable iff (!rstn) // RULE7
    at_data && pkt_ok && oct_num == `OCT_PTYPE && oct_data == `PT_CALL_ACC
    |=> pkt_q == frame_decoder_pkg::pkt_call_acc)
    else $error("call accepted missed");
  chk_pkt_info_only: assert property (@(posedge core_clk) disable iff (!rstn) // RULE7
    pkt_valid_q |-> class_q == frame_decoder_pkg::cls_info)
    else $error("packet fields flagged outside info frame");
  chk_flag_reset: assert property (@(posedge core_clk) disable iff (!rstn) // RULE8
    take && is_flag |=> pos_q == 4'h0 && in_frame_q)
    else $error("flag did not restart frame");
  // valid strobe rises one clock after control, holds until next address
  chk_valid_timing: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    at_ctrl |=> ctrl_valid_q)
    else $error("valid strobe late");
  chk_valid_rise: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    $rose(ctrl_valid_q) |-> $past(at_ctrl))
    else $error("valid strobe without control octet");
  chk_valid_hold: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    ctrl_valid_q && !at_addr |=> ctrl_valid_q)
    else $error("valid strobe dropped early");
  chk_enable_freeze: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    !ce |=> $stable(class_q) && $stable(pos_q) && $stable(pkt_q))
    else $error("state moved while enable low");
endmodule : frame_type_decoder
`default_nettype wire

//--- tb/link_station_model.sv
// far station model offering octets to the decoder
`timescale 1ns/1ps
`default_nettype none
module link_station_model (
  // clock
  input wire logic core_clk,
  // octet stream
  output logic oct_valid,
  output logic [7:0] oct_data
);
  // idle line at time zero
  initial begin
    oct_valid = 1'b0;
    oct_data = 8'h5A;
  end
  // release the line, data inverted so a stale octet never lingers
  task automatic rest();
    @(negedge core_clk);
    oct_valid = 1'b0;
    oct_data = ~oct_data;
  endtask : rest
  // one octet after gap idle cycles
  task automatic put(input logic [7:0] b, input int gap);
    repeat (gap) rest();
    @(negedge core_clk);
    oct_valid = 1'b1;
    oct_data = b;
  endtask : put
  // frame delimiter
  task automatic flag(input int gap);
    put(8'h7E, gap);
  endtask : flag
endmodule : link_station_model
`default_nettype wire

//--- tb/frame_type_decoder_tb.sv
// self-checking bench for the frame type decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t got %h exp %h", $time, a, e); end end
module frame_type_decoder_tb;
  logic core_clk, rstn, ce, oct_valid, ctrl_valid_q, poll_q, is_command_q, pkt_valid_q;
  logic [7:0] oct_data, own_addr, addr_lens_q, called_q, calling_q;
  logic [2:0] send_seq_q, recv_seq_q;
  logic [1:0] super_type_q;
  logic [5:0] fac_len_q;
  frame_decoder_pkg::frame_class_t class_q;
  frame_decoder_pkg::mode_cmd_t mode_q;
  frame_decoder_pkg::pkt_kind_t pkt_q;
  int error_cnt = 0;
  int n_compared = 0;
  int ec; // expected class of the last frame
  logic [7:0] tbl [16] = '{8'h22, 8'hA4, 8'h01, 8'h05, 8'h09, 8'h0D, 8'h83, 8'h93,
    8'h03, 8'h2F, 8'h3F, 8'hCF, 8'h4F, 8'h6F, 8'h7F, 8'h63};
  // device under test
  frame_type_decoder uut (.core_clk, .rstn, .ce, .oct_valid, .oct_data, .own_addr,
    .ctrl_valid_q, .class_q, .super_type_q, .mode_q, .poll_q, .send_seq_q, .recv_seq_q,
    .is_command_q, .pkt_valid_q, .pkt_q, .addr_lens_q, .called_q, .calling_q, .fac_len_q);
  // far station
  link_station_model stn (.core_clk, .oct_valid, .oct_data);
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // keep random octets off the flag value
  function automatic logic [7:0] nf(input logic [7:0] v);
    return (v == 8'h7E) ? 8'h7D : v;
  endfunction : nf
  // counts and verdict
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // every output at its reset value
  task automatic chk_reset();
    `CHK({ctrl_valid_q, class_q, super_type_q, mode_q, poll_q}, 9'h0)
    `CHK({send_seq_q, recv_seq_q, is_command_q, pkt_valid_q, pkt_q}, 10'h0)
    `CHK({addr_lens_q, called_q, calling_q, fac_len_q}, 30'h0)
  endtask : chk_reset
  // one frame with a call packet body, checked against the reference
  task automatic send_frame(input logic [7:0] c, input logic [7:0] pt);
    logic [7:0] ad;
    logic [7:0] b [$];
    int em;
    ad = nf(8'($urandom));
    own_addr = ($urandom_range(1) == 1) ? ad : ~ad;
    repeat (9) b.push_back(nf(8'($urandom)));
    b[2] = pt;
    stn.flag($urandom_range(2));
    stn.put(ad, $urandom_range(2));
    stn.put(c, $urandom_range(2));
    `CHK(ctrl_valid_q, 1'b0)
    stn.put(b[0], 0);
    ec = !c[0] ? 1 : ((c[1:0] == 2'b01) ? 2 : 3);
    case (c & 8'hEF)
      8'h83: em = 1;
      8'h03: em = 2;
      8'h2F: em = 3;
      8'hCF: em = 4;
      8'h4F: em = 5;
      8'h6F: em = 6;
      default: em = 0;
    endcase
    `CHK(ctrl_valid_q, 1'b1)
    `CHK(class_q, 2'(ec))
    `CHK(super_type_q, (ec == 2) ? c[3:2] : 2'h0)
    `CHK(mode_q, 3'((ec == 3) ? em : 0))
    `CHK(poll_q, c[4])
    `CHK(recv_seq_q, c[7:5])
    `CHK(send_seq_q, (ec == 1) ? c[3:1] : 3'h0)
    `CHK(is_command_q, 1'(ad != own_addr))
    for (int i = 1; i < 8; i++) stn.put(b[i], $urandom_range(2));
    if (ec == 1 && (pt == 8'h0B || pt == 8'h0F)) begin
      `CHK(pkt_valid_q, 1'b1)
      `CHK(pkt_q, (pt == 8'h0B) ? 2'h1 : 2'h2)
      `CHK(addr_lens_q, b[3])
      `CHK(called_q, b[4])
      `CHK(calling_q, b[5])
      `CHK(fac_len_q, b[6][5:0])
    end else begin
      `CHK(pkt_valid_q, 1'b0)
      `CHK(pkt_q, 2'h0)
    end
    stn.put(b[8], $urandom_range(2));
    stn.flag($urandom_range(2));
  endtask : send_frame
  // main sequence
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    own_addr = 8'h00;
    void'($urandom(24));
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    chk_reset();
    repeat (3) stn.put(8'h81, 1);
    stn.rest();
    `CHK(ctrl_valid_q, 1'b0)
    foreach (tbl[i]) send_frame(tbl[i], (i % 2) ? 8'h0B : 8'h0F);
    // synchronous reset in mid-run clears every output
    stn.rest();
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    chk_reset();
    // random frames; packet type call request, call accepted or unrecognised
    repeat (20) send_frame(nf(8'($urandom)), 8'(8'h0B + 4 * $urandom_range(2)));
    // enable low freezes the previous result
    ce = 1'b0;
    stn.flag(0);
    stn.put(8'h55, 0);
    stn.put((ec == 2) ? 8'h03 : 8'h01, 0);
    stn.put(8'h10, 0);
    stn.rest();
    `CHK(ctrl_valid_q, 1'b1)
    `CHK(class_q, 2'(ec))
    ce = 1'b1;
    print_verdict();
  end
  // hang guard, far beyond the under 1400 cycles the frames take
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule : frame_type_decoder_tb
`default_nettype wire
